// >>> hw/gdp_defs.svh
// Register indices, reset values, field masks and timing counts for the
// dual GPIO port pin control block.
// Assumes an APB slave that decodes paddr[11:2] against the low index bits.
//
// How it works
// - Port-2 pull-up select, byte/bit, resets 00H.
// - Port-2 drive type 0 means push-pull.
// - Port-2 drive type only bits 0-2,4,5.
// - Port 3 eight pins, per-pin direction.
// - Direction 0 output, 1 input, reset FFH.
// - Port-3 direction accepts byte and bit access.
// - Output-mode latch write drives pin two pclk cycles after the write.
// - Input-mode read returns pin; write only latch.
// - Output-mode read returns latch value.
// - Port-3 open-drain choice only pins 3, 4.
// - Port-3 pull-up select, byte/bit, resets 00H.
// - Timer inputs four, five pass noise filter.
// - Pin drives latch OR alternate output.
// - Reset returns all port-3 pins to input.
// - Port-2 direction byte/bit, reset FFH, 0 output.
// - Port-2 latch always stores, drives in output.
`ifndef GDP_DEFS_SVH
`define GDP_DEFS_SVH

`define GDP_IDX_P2_LATCH 32'hFFFF_F004
`define GDP_IDX_P3_LATCH 32'hFFFF_F006
`define GDP_IDX_P2_DIR 32'hFFFF_F024
`define GDP_IDX_P3_DIR 32'hFFFF_F026
`define GDP_IDX_P2_PU 32'h0FFF_F084
`define GDP_IDX_P3_PU 32'hFFFF_F086
`define GDP_IDX_P2_OD 32'hFFFF_F0A4
`define GDP_IDX_P3_OD 32'hFFFF_F0A6

`define GDP_RST_LATCH 8'h00
`define GDP_RST_DIR 8'hFF
`define GDP_RST_PU 8'h00
`define GDP_RST_OD 8'h00

`define GDP_P2_OD_MASK 8'h37
`define GDP_P3_OD_MASK 8'h18

`define GDP_NF_SAMPLES 2'h3

`endif

// >>> hw/gdp_noise_filter.sv
// Digital noise eliminator for a timer input: output follows the input
// only after it differs for a fixed number of consecutive samples.
// Assumes its input is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "gdp_defs.svh"
module gdp_noise_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_sync,
   output logic filt_o
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic filt_nxt;

   always_comb begin
      cnt_nxt = 2'h0;
      filt_nxt = filt_o;
      if (in_sync != filt_o) begin
         if (cnt_r == `GDP_NF_SAMPLES - 2'h1) begin
            filt_nxt = in_sync;
         end else begin
            cnt_nxt = cnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 2'h0;
         filt_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         filt_o <= filt_nxt;
      end
   end

   filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(filt_o) |-> ($past(in_sync, 1) == filt_o && $past(in_sync, 2) == filt_o
         && $past(in_sync, 3) == filt_o))
      else $error("filter passed a pulse shorter than the sample count");
endmodule
`default_nettype wire

// >>> hw/gdp_pin_cell.sv
// One pin driver: merges latch and alternate output, applies direction
// and drive type, registers the pad controls.
// Assumes settings come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gdp_pin_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic latch,
   input wire logic dir,
   input wire logic alt,
   input wire logic od_sel,
   input wire logic pu_sel,
   output logic pin_o,
   output logic pin_oe,
   output logic pu_en
);
   logic eff;
   logic o_nxt;
   logic oe_nxt;

   always_comb begin
      eff = latch | alt;
      o_nxt = od_sel ? 1'b0 : eff;
      oe_nxt = ~dir & (od_sel ? ~eff : 1'b1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
         pu_en <= 1'b0;
      end else begin
         pin_o <= o_nxt;
         pin_oe <= oe_nxt;
         pu_en <= pu_sel;
      end
   end

   or_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!od_sel && !dir) |=> (pin_oe && pin_o == $past(latch | alt)))
      else $error("push-pull pin not driving latch OR alternate");
   od_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      (od_sel && !dir && !(latch | alt)) |=> (pin_oe && !pin_o))
      else $error("open-drain pin not pulling low");
   od_float_a: assert property (@(posedge pclk) disable iff (!presetn)
      (od_sel && (latch | alt)) |=> !pin_oe)
      else $error("open-drain pin driven while output is high");
   in_float_a: assert property (@(posedge pclk) disable iff (!presetn)
      dir |=> !pin_oe)
      else $error("input-mode pin driven");
   od_cov: cover property (@(posedge pclk) disable iff (!presetn)
      od_sel && !dir && !eff);
endmodule
`default_nettype wire

// >>> hw/gdp_pkg.sv
// Shared types for the dual GPIO port pin control block.
// Assumes gdp_defs.svh carries the numeric constants.
package gdp_pkg;
   typedef logic [7:0] gdp_byte_t;

   typedef struct packed {
      gdp_byte_t latch;
      gdp_byte_t dir;
      gdp_byte_t pu;
      gdp_byte_t od;
   } gdp_port_s;

   typedef struct packed {
      gdp_byte_t o;
      gdp_byte_t oe;
      gdp_byte_t pu;
   } gdp_pins_s;
endpackage

// >>> hw/gdp_top.sv
// APB register file and pin control for two 8-bit GPIO ports.
// Assumes pins are from outside the clock domain, alternate outputs and
// address mode enables come from on-chip logic on pclk.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gdp_defs.svh"
module gdp_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] p2_pin_i,
   input wire logic [7:0] p3_pin_i,
   input wire logic [7:0] p2_alt_o,
   input wire logic [7:0] p3_alt_o,
   input wire logic [2:0] address_output_mode_reg,
   input wire logic [2:0] ext_address_bits,
   output var gdp_pkg::gdp_pins_s p2_pins,
   output var gdp_pkg::gdp_pins_s p3_pins,
   output logic timer_input_four,
   output logic timer_input_five
);
   localparam logic [31:0] IDX_P2_LATCH = `GDP_IDX_P2_LATCH;
   localparam logic [31:0] IDX_P3_LATCH = `GDP_IDX_P3_LATCH;
   localparam logic [31:0] IDX_P2_DIR = `GDP_IDX_P2_DIR;
   localparam logic [31:0] IDX_P3_DIR = `GDP_IDX_P3_DIR;
   localparam logic [31:0] IDX_P2_PU = `GDP_IDX_P2_PU;
   localparam logic [31:0] IDX_P3_PU = `GDP_IDX_P3_PU;
   localparam logic [31:0] IDX_P2_OD = `GDP_IDX_P2_OD;
   localparam logic [31:0] IDX_P3_OD = `GDP_IDX_P3_OD;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [7:0] p2_meta_r;
   logic [7:0] p2_sync_r;
   logic [7:0] p3_meta_r;
   logic [7:0] p3_sync_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_meta_r <= 8'h00;
         p2_sync_r <= 8'h00;
         p3_meta_r <= 8'h00;
         p3_sync_r <= 8'h00;
      end else begin
         p2_meta_r <= p2_pin_i;
         p2_sync_r <= p2_meta_r;
         p3_meta_r <= p3_pin_i;
         p3_sync_r <= p3_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave and registers

   gdp_pkg::gdp_port_s p2_r;
   gdp_pkg::gdp_port_s p2_nxt;
   gdp_pkg::gdp_port_s p3_r;
   gdp_pkg::gdp_port_s p3_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt;
   logic pslverr_nxt;
   logic [9:0] idx;
   logic hit;
   logic setup;
   logic wr_go;
   gdp_pkg::gdp_byte_t rd_byte;
   gdp_pkg::gdp_byte_t wbyte;

   assign idx = paddr[11:2];
   assign setup = psel & ~penable;
   assign wbyte = pwdata[7:0];
   // Bit access from the CPU arrives as a byte write on lane 0
   assign wr_go = psel & penable & pwrite & pready & ~pslverr & pstrb[0];

   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      unique case (idx)
         IDX_P2_LATCH[9:0]: rd_byte = (p2_r.dir & p2_sync_r) | (~p2_r.dir & p2_r.latch);
         IDX_P3_LATCH[9:0]: rd_byte = (p3_r.dir & p3_sync_r) | (~p3_r.dir & p3_r.latch);
         IDX_P2_DIR[9:0]: rd_byte = p2_r.dir;
         IDX_P3_DIR[9:0]: rd_byte = p3_r.dir;
         IDX_P2_PU[9:0]: rd_byte = p2_r.pu;
         IDX_P3_PU[9:0]: rd_byte = p3_r.pu;
         IDX_P2_OD[9:0]: rd_byte = p2_r.od;
         IDX_P3_OD[9:0]: rd_byte = p3_r.od;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      // Zero-wait answer: setup cycle primes pready for the access phase
      pready_nxt = setup;
      pslverr_nxt = setup & ~hit;
      prdata_nxt = (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      p2_nxt = p2_r;
      p3_nxt = p3_r;
      if (wr_go) begin
         unique case (idx)
            IDX_P2_LATCH[9:0]: p2_nxt.latch = wbyte;
            IDX_P3_LATCH[9:0]: p3_nxt.latch = wbyte;
            IDX_P2_DIR[9:0]: p2_nxt.dir = wbyte;
            IDX_P3_DIR[9:0]: p3_nxt.dir = wbyte;
            IDX_P2_PU[9:0]: p2_nxt.pu = wbyte;
            IDX_P3_PU[9:0]: p3_nxt.pu = wbyte;
            IDX_P2_OD[9:0]: p2_nxt.od = wbyte & `GDP_P2_OD_MASK;
            IDX_P3_OD[9:0]: p3_nxt.od = wbyte & `GDP_P3_OD_MASK;
            default: p2_nxt = p2_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_r <= {`GDP_RST_LATCH, `GDP_RST_DIR, `GDP_RST_PU, `GDP_RST_OD};
         p3_r <= {`GDP_RST_LATCH, `GDP_RST_DIR, `GDP_RST_PU, `GDP_RST_OD};
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         p2_r <= p2_nxt;
         p3_r <= p3_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers

   gdp_pkg::gdp_byte_t p3_alt;

   // Address outputs rely on software clearing direction and latch bits 4-6
   assign p3_alt = p3_alt_o | {1'b0, ext_address_bits & address_output_mode_reg, 4'h0};

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         gdp_pin_cell u_p2 (
            .pclk(pclk),
            .presetn(presetn),
            .latch(p2_r.latch[g]),
            .dir(p2_r.dir[g]),
            .alt(p2_alt_o[g]),
            .od_sel(p2_r.od[g]),
            .pu_sel(p2_r.pu[g]),
            .pin_o(p2_pins.o[g]),
            .pin_oe(p2_pins.oe[g]),
            .pu_en(p2_pins.pu[g])
         );
         gdp_pin_cell u_p3 (
            .pclk(pclk),
            .presetn(presetn),
            .latch(p3_r.latch[g]),
            .dir(p3_r.dir[g]),
            .alt(p3_alt[g]),
            .od_sel(p3_r.od[g]),
            .pu_sel(p3_r.pu[g]),
            .pin_o(p3_pins.o[g]),
            .pin_oe(p3_pins.oe[g]),
            .pu_en(p3_pins.pu[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Timer inputs through noise eliminator

   gdp_noise_filter u_nf_four (
      .pclk(pclk),
      .presetn(presetn),
      .in_sync(p3_sync_r[6]),
      .filt_o(timer_input_four)
   );

   gdp_noise_filter u_nf_five (
      .pclk(pclk),
      .presetn(presetn),
      .in_sync(p3_sync_r[7]),
      .filt_o(timer_input_five)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property wr_lands(logic [9:0] ri, logic [7:0] q);
      (wr_go && idx == ri) |=> (q == $past(wbyte));
   endproperty

   pu2_write_a: assert property (wr_lands(IDX_P2_PU[9:0], p2_r.pu))
      else $error("port2 pull-up write lost");
   pu3_write_a: assert property (wr_lands(IDX_P3_PU[9:0], p3_r.pu))
      else $error("port3 pull-up write lost");
   pm3_write_a: assert property (wr_lands(IDX_P3_DIR[9:0], p3_r.dir))
      else $error("port3 direction write lost");
   p2_latch_a: assert property (wr_lands(IDX_P2_LATCH[9:0], p2_r.latch))
      else $error("port2 latch write lost");
   pf2_mask_a: assert property ((p2_r.od & ~`GDP_P2_OD_MASK) == 8'h00)
      else $error("port2 drive type has unimplemented bit set");
   pf3_mask_a: assert property ((p3_r.od & ~`GDP_P3_OD_MASK) == 8'h00)
      else $error("port3 drive type outside pins 3 and 4");
   stable_cfg_a: assert property (!wr_go |=> $stable(p3_r) && $stable(p2_r))
      else $error("settings changed without a bus write");
   rd_mix_a: assert property ((setup && !pwrite && idx == IDX_P3_LATCH[9:0])
      |=> prdata[7:0] == $past((p3_r.dir & p3_sync_r) | (~p3_r.dir & p3_r.latch)))
      else $error("port3 data read mixes pin and latch wrongly");
   drive_now_a: assert property ((wr_go && idx == IDX_P3_LATCH[9:0] && !p3_r.dir[0]
      && !p3_r.od[0] && !p3_alt[0]) |=> ##1 (p3_pins.oe[0] && p3_pins.o[0] == $past(wbyte[0], 2)))
      else $error("port3 latch write did not reach pin");
   ans_a: assert property (setup |=> pready ##1 !pready)
      else $error("APB answer not one cycle after setup");

   wr_p3_c: cover property (wr_go && idx == IDX_P3_LATCH[9:0]);
   rd_in_c: cover property (setup && !pwrite && idx == IDX_P3_LATCH[9:0] && p3_r.dir == 8'hFF);
   err_c: cover property (pready && pslverr);
endmodule
`default_nettype wire

// >>> tb/dual_gpio_port_pin_control_test.sv
// Self-checking bench for the dual port block: APB master, pad models.
// Assumes gdp_top with zero-wait APB and one flop stage to the pads.
`timescale 1ns/1ps
`default_nettype none
`include "gdp_defs.svh"
module dual_gpio_port_pin_control_test;
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, seed = 32'h24;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, ti4, ti5;
   logic [7:0] p2_in, p3_in, ext2 = '0, ext3 = '0, alt2 = '0, alt3 = '0;
   logic [7:0] v, lat_v, alt_v, pull_v, eff;
   logic [2:0] amode = '0, abits = '0;
   gdp_pkg::gdp_pins_s p2_pins, p3_pins;
   logic [32:0] q[$];
   int fail_count = 0, cmp_count = 0;

   gdp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .p2_pin_i(p2_in), .p3_pin_i(p3_in),
      .p2_alt_o(alt2), .p3_alt_o(alt3), .address_output_mode_reg(amode),
      .ext_address_bits(abits), .p2_pins(p2_pins), .p3_pins(p3_pins),
      .timer_input_four(ti4), .timer_input_five(ti5));
   gdp_pin_model u_pad2 (.pins(p2_pins), .ext(ext2), .pin_i(p2_in));
   gdp_pin_model u_pad3 (.pins(p3_pins), .ext(ext3), .pin_i(p3_in));

   initial begin
      forever #12.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t pad got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] idx, input logic [7:0] d,
         input logic [32:0] e);
      q.push_back(e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx[9:0], 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [31:0] idx, input logic [7:0] d);
      xfer(1'h1, idx, d, 33'h0);
   endtask
   task automatic rd(input logic [31:0] idx, input logic [7:0] d);
      xfer(1'h0, idx, 8'h00, {25'h0, d});
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask
   // Write slots expect zero data; read slots the modelled register value
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1) begin
         cmp_count++;
         if (q.size() == 0 || {pslverr, prdata} !== q[0]) begin
            fail_count++;
            $display("[ERR] %0t bus got %h", $time, {pslverr, prdata});
         end
         if (q.size() != 0) void'(q.pop_front());
      end
   end
   task final_report();
      $display("Checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      fail_count++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      rd(`GDP_IDX_P2_PU, 8'h00);
      rd(`GDP_IDX_P3_DIR, 8'hFF);
      rd(`GDP_IDX_P2_DIR, 8'hFF);
      rd(`GDP_IDX_P3_PU, 8'h00);
      chk(p3_pins.oe, 8'h00);
      $display("reset test done");
      v = rnd();
      wr(`GDP_IDX_P2_PU, v);
      rd(`GDP_IDX_P2_PU, v);
      wr(`GDP_IDX_P2_OD, 8'hFF);
      rd(`GDP_IDX_P2_OD, 8'h37);
      wr(`GDP_IDX_P3_OD, 8'hFF);
      rd(`GDP_IDX_P3_OD, 8'h18);
      pstrb <= 4'h0;
      wr(`GDP_IDX_P3_DIR, 8'h00);
      pstrb <= 4'hF;
      rd(`GDP_IDX_P3_DIR, 8'hFF);
      xfer(1'h1, 32'h3FF, 8'h5A, {1'h1, 32'h0});
      xfer(1'h0, 32'h3FF, 8'h00, {1'h1, 32'h0});
      $display("register test done");
      // Software keeps address positions 4..6 of the latch clear
      lat_v = rnd() & 8'h8F;
      alt_v = rnd();
      pull_v = rnd();
      v = rnd();
      wr(`GDP_IDX_P3_PU, pull_v);
      wr(`GDP_IDX_P3_LATCH, lat_v);
      wr(`GDP_IDX_P3_DIR, 8'h00);
      alt3 <= alt_v;
      amode <= 3'h7;
      abits <= v[2:0];
      settle();
      eff = lat_v | alt_v | {1'h0, v[2:0], 4'h0};
      chk(p3_pins.oe, ~(eff & 8'h18));
      chk(p3_pins.o, eff & 8'hE7);
      chk(p3_pins.pu, pull_v);
      rd(`GDP_IDX_P3_LATCH, lat_v);
      $display("output test done");
      alt3 <= '0;
      amode <= '0;
      v = rnd();
      ext3 <= v;
      wr(`GDP_IDX_P3_DIR, 8'hFF);
      wr(`GDP_IDX_P3_LATCH, 8'hA5);
      repeat (4) @(posedge pclk);
      rd(`GDP_IDX_P3_LATCH, v | pull_v);
      chk(p3_pins.oe, 8'h00);
      wr(`GDP_IDX_P3_DIR, 8'h00);
      rd(`GDP_IDX_P3_LATCH, 8'hA5);
      wr(`GDP_IDX_P3_LATCH, 8'h5B);
      settle();
      chk(p3_pins.o, 8'h43);
      chk(p3_pins.oe, 8'hE7);
      $display("input test done");
      lat_v = rnd();
      alt_v = rnd();
      wr(`GDP_IDX_P2_LATCH, lat_v);
      alt2 <= alt_v;
      wr(`GDP_IDX_P2_DIR, 8'h00);
      settle();
      eff = lat_v | alt_v;
      chk(p2_pins.oe, ~(eff & 8'h37));
      chk(p2_pins.o, eff & 8'hC8);
      $display("port two test done");
      ext3 <= 8'h00;
      wr(`GDP_IDX_P3_PU, 8'h00);
      wr(`GDP_IDX_P3_DIR, 8'hFF);
      repeat (8) @(posedge pclk);
      ext3 <= 8'h80;
      repeat (2) @(posedge pclk);
      ext3 <= 8'h00;
      repeat (8) @(posedge pclk);
      #1;
      chk({6'h0, ti5, ti4}, 8'h00);
      @(posedge pclk);
      ext3 <= 8'h40;
      repeat (8) @(posedge pclk);
      #1;
      chk({6'h0, ti5, ti4}, 8'h01);
      $display("filter test done");
      repeat (2) @(posedge pclk);
      final_report();
   end
endmodule
`default_nettype wire

// >>> tb/gdp_pin_model.sv
// Pad model for one 8-bit port: resolves driver, pull-up and outside level.
// Assumes pad controls from the port block and an outside level from the bench.
`timescale 1ns/1ps
`default_nettype none
module gdp_pin_model (
   input wire gdp_pkg::gdp_pins_s pins,
   input wire logic [7:0] ext,
   output logic [7:0] pin_i
);
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         // Released pad: pull-up wins, else the bench keeps it moving
         pin_i[i] = pins.oe[i] ? pins.o[i] : (pins.pu[i] ? 1'h1 : ext[i]);
      end
   end
endmodule
`default_nettype wire
